/* hdl/hbd_host_bus_address_decode.sv */
`timescale 1ns/1ps

// How it works
// - Fitted jumper reads low, absent reads high; straps taken as static.
// - SA7..SA3 against five straps pick I/O base 300H..3F8H.
// - Only ten address bits decoded; four ports at base+0..3.
// - SA16..SA13 against four straps pick 8K ROM base C000H..DE00H.
// - ROM decode uses SA19..SA13 only and ignores AEN.
// - AEN active suppresses the port decode.
// - Port access needs AEN inactive and a matching port offset.
// - While owning the bus, drive address, memory strobes and data; the module drives only the read strobe memrN, and data on writes only.
// - Address valid one system period before memory read strobe.
// - Low data byte carries the least significant byte and commands.
// - Straps pick DMA pair 5, 6 or 7 and one interrupt line.
// - No address latch strobe used; decode straight from address.
// - Master after acknowledge; release bus within 15 us.
// - One period before driving lines, two before any strobe.
module hbd_host_bus_address_decode #(
    parameter int OWN_MAX = hbd_pkg::OWN_MAX_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire hbd_pkg::hbd_strap_type strapN,
    input wire hbd_pkg::hbd_hostin_type hostIn,
    input wire logic [15:0] sdIn,
    input wire logic [2:0] dackN,
    output logic [2:0] drq,
    output logic [9:0] irqOut,
    output logic masterN,
    output logic [19:0] saOut,
    output logic saOe,
    output logic memrN,
    output logic memrOe,
    output logic [15:0] sdOut,
    output logic sdOe,
    output logic ioSelN,
    output logic romSelN,
    output logic [1:0] portIdx
);

    // ==========================================================
    // Pin synchronisers, three stages; change taken when 2 and 3 agree
    hbd_pkg::hbd_hostin_type hin1_r, hin2_r, hin3_r, hin_r;
    logic [2:0] dk1_r, dk2_r, dk3_r, dk_r;
    logic [15:0] sd1_r, sd2_r, sd3_r, sd_r;
    hbd_pkg::hbd_strap_type st1_r, st2_r, st3_r, st_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hin1_r <= '1;
            hin2_r <= '1;
            hin3_r <= '1;
            hin_r <= '1;
        end else begin
            hin1_r <= hostIn;
            hin2_r <= hin1_r;
            hin3_r <= hin2_r;
            if (hin2_r == hin3_r) begin
                hin_r <= hin3_r;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dk1_r <= '1;
            dk2_r <= '1;
            dk3_r <= '1;
            dk_r <= '1;
            sd1_r <= '0;
            sd2_r <= '0;
            sd3_r <= '0;
            sd_r <= '0;
        end else begin
            dk1_r <= dackN;
            dk2_r <= dk1_r;
            dk3_r <= dk2_r;
            if (dk2_r == dk3_r) begin
                dk_r <= dk3_r;
            end
            sd1_r <= sdIn;
            sd2_r <= sd1_r;
            sd3_r <= sd2_r;
            if (sd2_r == sd3_r) begin
                sd_r <= sd3_r;
            end
        end
    end

    // Jumper fitted pulls low; absent floats high, so bits are used as-is
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st1_r <= '1;
            st2_r <= '1;
            st3_r <= '1;
            st_r <= '1;
        end else begin
            st1_r <= strapN;
            st2_r <= st1_r;
            st3_r <= st2_r;
            if (st2_r == st3_r) begin
                st_r <= st3_r;
            end
        end
    end

    // ==========================================================
    // Address decode, no latch strobe needed
    logic ioHit, romHit;
    always_comb begin
        ioHit = (hin_r.addr[9:8] == hbd_pkg::IO_BASE_MIN[9:8])
            && (hin_r.addr[7:3] == st_r.ioSel)
            && (hin_r.addr[2] == 1'b0)
            && !hin_r.aen;
        romHit = (hin_r.addr[19:17] == hbd_pkg::ROM_BASE_MIN[19:17])
            && (hin_r.addr[16:13] == st_r.romSel);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ioSelN <= 1'b1;
            romSelN <= 1'b1;
            portIdx <= '0;
        end else begin
            ioSelN <= !(ioHit && !(hin_r.iorN && hin_r.iowN));
            romSelN <= !(romHit && !hin_r.memrN);
            portIdx <= hin_r.addr[1:0];
        end
    end

    // ==========================================================
    // Channel selection
    hbd_pkg::hbd_dma_type dmaCh;
    assign dmaCh = hbd_pkg::hbd_dma_type'(st_r.dmaSel);

    // ==========================================================
    // Bus master sequencer
    typedef enum logic [2:0] {
        M_IDLE, M_REQ, M_OWN, M_ADDR, M_STRB, M_DONE
    } hbd_mst_type;
    hbd_mst_type mst_r;
    logic [hbd_pkg::CNT_W-1:0] ph_r;
    logic [hbd_pkg::CNT_W-1:0] own_r;
    logic go, goWr, busy_r, wr_r, tout_r;
    logic [19:0] madr_r;
    logic [15:0] mwd_r, mrd_r;
    logic dkOk;

    // Data bus comes through the pin synchroniser, so the read strobe
    // stands two system periods to let the sampled data settle
    localparam logic [hbd_pkg::CNT_W-1:0] PH_LAST =
        hbd_pkg::CNT_W'(hbd_pkg::SYS_CYC - 1);
    localparam logic [hbd_pkg::CNT_W-1:0] STRB_LAST =
        hbd_pkg::CNT_W'(2 * hbd_pkg::SYS_CYC - 1);

    always_comb begin
        unique case (dmaCh)
            hbd_pkg::DMA_CH5: dkOk = !dk_r[0];
            hbd_pkg::DMA_CH6: dkOk = !dk_r[1];
            hbd_pkg::DMA_CH7: dkOk = !dk_r[2];
            hbd_pkg::DMA_NONE: dkOk = 1'b0;
        endcase
    end

    // Aborting at the ownership limit keeps refresh alive at a cost of data
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mst_r <= M_IDLE;
            ph_r <= '0;
            own_r <= '0;
            tout_r <= 1'b0;
            mrd_r <= '0;
        end else begin
            ph_r <= ph_r + 1'b1;
            own_r <= (mst_r == M_IDLE || mst_r == M_REQ) ? '0 : own_r + 1'b1;
            if (go) begin
                tout_r <= 1'b0;
            end
            unique case (mst_r)
                M_IDLE: if (go) begin
                    mst_r <= M_REQ;
                end
                M_REQ: if (dkOk) begin
                    mst_r <= M_OWN;
                    ph_r <= '0;
                end
                M_OWN: if (ph_r == PH_LAST) begin
                    mst_r <= M_ADDR;
                    ph_r <= '0;
                end
                M_ADDR: if (ph_r == PH_LAST) begin
                    mst_r <= M_STRB;
                    ph_r <= '0;
                end
                M_STRB: if (ph_r == STRB_LAST) begin
                    mst_r <= M_DONE;
                    mrd_r <= sd_r;
                end
                M_DONE: mst_r <= M_IDLE;
            endcase
            if (mst_r != M_IDLE && mst_r != M_REQ && mst_r != M_DONE
                    && own_r >= hbd_pkg::CNT_W'(OWN_MAX - 1)) begin
                mst_r <= M_DONE;
                tout_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            drq <= '0;
            masterN <= 1'b1;
            saOe <= 1'b0;
            sdOe <= 1'b0;
            memrOe <= 1'b0;
            memrN <= 1'b1;
            saOut <= '0;
            sdOut <= '0;
        end else begin
            drq <= '0;
            // Cascade request stays up for the whole tenure of the bus
            if (mst_r inside {M_REQ, M_OWN, M_ADDR, M_STRB}
                    && dmaCh != hbd_pkg::DMA_NONE) begin
                drq[dmaCh] <= 1'b1;
            end
            masterN <= !(mst_r inside {M_OWN, M_ADDR, M_STRB});
            saOe <= mst_r inside {M_ADDR, M_STRB};
            memrOe <= mst_r inside {M_ADDR, M_STRB};
            sdOe <= wr_r && (mst_r inside {M_ADDR, M_STRB});
            memrN <= !(mst_r == M_STRB && !wr_r);
            saOut <= madr_r;
            sdOut <= mwd_r;
        end
    end

    // Interrupt line follows the strap choice; driven while a fault stands
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irqOut <= '0;
        end else begin
            irqOut <= '0;
            if (tout_r && st_r.irqSel < 4'd10) begin
                irqOut[st_r.irqSel] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // AHB-Lite slave, zero wait state
    logic aph_r, awr_r;
    logic [7:0] aad_r;
    assign go = aph_r && awr_r && aad_r == hbd_pkg::CTRL_OFS
        && hwdata[hbd_pkg::CTRL_GO_BIT] && !busy_r;
    assign goWr = hwdata[hbd_pkg::CTRL_WR_BIT];
    assign busy_r = (mst_r != M_IDLE);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aph_r <= 1'b0;
            awr_r <= 1'b0;
            aad_r <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready) begin
                aph_r <= hsel && htrans[1] && hsize == 3'd2;
                awr_r <= hwrite;
                aad_r <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_r <= 1'b0;
            madr_r <= '0;
            mwd_r <= '0;
        end else if (aph_r && awr_r && !busy_r) begin
            if (go) begin
                wr_r <= goWr;
            end
            if (aad_r == hbd_pkg::MADDR_OFS) begin
                madr_r <= hwdata[19:0];
            end
            if (aad_r == hbd_pkg::WDATA_OFS) begin
                mwd_r <= hwdata[15:0];
            end
        end
    end

    logic [31:0] rd;
    always_comb begin
        rd = '0;
        unique case (haddr[7:0])
            hbd_pkg::CTRL_OFS: rd = {30'h0, wr_r, 1'b0};
            hbd_pkg::STAT_OFS: rd = {28'h0, !ioSelN, !romSelN, tout_r, busy_r};
            hbd_pkg::MADDR_OFS: rd = {12'h0, madr_r};
            hbd_pkg::WDATA_OFS: rd = {16'h0, mwd_r};
            hbd_pkg::RDATA_OFS: rd = {16'h0, mrd_r};
            hbd_pkg::STRAP_OFS: rd = {17'h0, st_r};
            default: rd = '0;
        endcase
    end

    // Loaded at the address phase so the data phase needs no wait state;
    // a read right behind a write to one register sees the old value
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hrdata <= '0;
        end else if (hready && hsel && htrans[1] && !hwrite
                && hsize == 3'd2) begin
            hrdata <= rd;
        end
    end

endmodule // hbd_host_bus_address_decode

/* hdl/hbd_pkg.sv */
package hbd_pkg;

    // ==========================================================
    // Register map (byte addresses on the register bus)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] MADDR_OFS = 8'h08;
    localparam logic [7:0] WDATA_OFS = 8'h0c;
    localparam logic [7:0] RDATA_OFS = 8'h10;
    localparam logic [7:0] STRAP_OFS = 8'h14;

    // Control bits
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WR_BIT = 1;

    // ==========================================================
    // Window bases
    localparam logic [9:0] IO_BASE_MIN = 10'h300;
    localparam logic [19:0] ROM_BASE_MIN = 20'hc0000;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 25;
    localparam int OWN_MAX_NS = 15000;
    // Longest time rounds down
    localparam int OWN_MAX_CYC = OWN_MAX_NS * CLK_MHZ / 1000;
    localparam int SYS_PERIOD_NS = 125;
    // Least time rounds up
    localparam int SYS_CYC = (SYS_PERIOD_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 12;

    typedef enum logic [1:0] {
        DMA_CH5,
        DMA_CH6,
        DMA_CH7,
        DMA_NONE
    } hbd_dma_type;

    typedef struct packed {
        logic [4:0] ioSel;
        logic [3:0] romSel;
        logic [1:0] dmaSel;
        logic [3:0] irqSel;
    } hbd_strap_type;

    typedef struct packed {
        logic [19:0] addr;
        logic aen;
        logic iorN;
        logic iowN;
        logic memrN;
    } hbd_hostin_type;

endpackage

/* verification/hbd_decode_properties.sv */
`timescale 1ns/1ps

// ==========================================================
// Port checks
module hbd_decode_checker #(
    parameter int OWN_MAX = 375
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire hbd_pkg::hbd_strap_type strapN,
    input wire hbd_pkg::hbd_hostin_type hostIn,
    input wire logic [2:0] dackN,
    input wire logic [2:0] drq,
    input wire logic masterN,
    input wire logic saOe,
    input wire logic memrN,
    input wire logic memrOe,
    input wire logic ioSelN,
    input wire logic romSelN,
    input wire logic [1:0] portIdx
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [15:0] ownCnt_r;
    logic ioHit, romHit;
    assign ioHit = hostIn.addr[9:2] == {2'h3, strapN.ioSel, 1'h0};
    assign romHit = hostIn.addr[19:13] == {3'h6, strapN.romSel};
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ownCnt_r <= 16'h0000;
        end else begin
            ownCnt_r <= masterN ? 16'h0000 : ownCnt_r + 16'h0001;
        end
    end
    // Inputs held long enough for the synchronisers to settle
    sequence settled;
        $stable({hostIn, strapN})[*8];
    endsequence
    AST_AEN_NO_IO: assert property (settled ##0 hostIn.aen |-> ioSelN)
        else $error("io select during aen");
    AST_IO_MISS: assert property (settled ##0 !ioHit |-> ioSelN)
        else $error("io select off window");
    AST_IO_HIT: assert property (
        settled ##0 (ioHit && !hostIn.aen && !hostIn.iorN) |-> !ioSelN)
        else $error("io port missed");
    AST_PORT_IDX: assert property (
        settled |-> portIdx == hostIn.addr[1:0])
        else $error("port index wrong");
    AST_ROM_HIT: assert property (
        settled ##0 (romHit && !hostIn.memrN) |-> !romSelN)
        else $error("rom missed");
    AST_ROM_MISS: assert property (settled ##0 !romHit |-> romSelN)
        else $error("rom select off window");
    AST_OWN_LIMIT: assert property (ownCnt_r <= OWN_MAX)
        else $error("bus held too long");
    AST_MASTER_ON_ACK: assert property (
        $fell(masterN) |-> dackN != 3'h7)
        else $error("master without acknowledge");
    AST_STROBE_LATE: assert property (
        $fell(memrN) |-> $past(saOe, 4) && !$past(masterN, 8))
        else $error("read strobe too early");
    AST_DRIVE_DELAY: assert property (
        $rose(saOe) |-> !$past(masterN, 4))
        else $error("address driven too early");
    AST_DRIVE_OWNED: assert property ((saOe || memrOe) |-> !masterN)
        else $error("driving bus while not master");
    AST_DRQ_ONE: assert property ($onehot0(drq))
        else $error("several requests");
endmodule // hbd_decode_checker

bind hbd_host_bus_address_decode hbd_decode_checker #(.OWN_MAX(OWN_MAX)) chk (
    .sys_clk, .rst, .strapN, .hostIn, .dackN, .drq, .masterN, .saOe,
    .memrN, .memrOe, .ioSelN, .romSelN, .portIdx
);

/* verification/hbd_host_bus_address_decode_tb_top.sv */
`timescale 1ns/1ps

// ==========================================================
// Bench
module hbd_host_bus_address_decode_tb_top;
    logic sys_clk, rst, hsel, hwrite, hready, hresp, hreadyout, slow;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans, portIdx;
    logic [2:0] hsize, dackN, drq;
    hbd_pkg::hbd_strap_type strapN;
    hbd_pkg::hbd_hostin_type hostIn;
    logic [15:0] sdIn, sdOut;
    logic [9:0] irqOut;
    logic [19:0] saOut;
    logic masterN, saOe, memrN, memrOe, sdOe, ioSelN, romSelN;
    int bad_count, num_checks, n;
    assign hready = hreadyout;
    hbd_host_bus_address_decode #(.OWN_MAX(40)) dut (
        .sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .strapN, .hostIn, .sdIn,
        .dackN, .drq, .irqOut, .masterN, .saOut, .saOe, .memrN, .memrOe,
        .sdOut, .sdOe, .ioSelN, .romSelN, .portIdx
    );
    hbd_host_model model (.sys_clk, .rst, .slow, .drq, .saOut, .saOe,
        .memrN, .memrOe, .dackN, .sdIn);

    task automatic step(inout int k);
        @(posedge sys_clk);
        k++;
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge sys_clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'h1);
        q = hrdata;
    endtask
    task automatic host(input logic [19:0] a, input logic aen, ior, memr);
        hostIn <= {a, aen, ior, 1'h1, memr};
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic chk_val(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({19'h0, got}, {19'h0, exp});
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        #(40 * 5000);
        bad_count++;
        final_report();
    end
    initial begin
        logic [4:0] ios [3];
        logic [3:0] roms [3];
        logic [9:0] b;
        logic [19:0] r;
        ios = '{5'h00, 5'h1f, 5'h0a};
        roms = '{4'h0, 4'hf, 4'h5};
        rst = 1'h1;
        {hwrite, slow, htrans, haddr, hwdata} = '0;
        hsel = 1'h1;
        hsize = 3'h2;
        strapN = {5'h00, 4'h0, 2'h3, 4'h3};
        hostIn = {20'h00000, 4'hf};
        repeat (20) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        foreach (ios[i]) begin
            strapN.ioSel <= ios[i];
            b = {2'h3, ios[i], 3'h0};
            for (int k = 0; k < 5; k++) begin
                host({10'h2a5, b + 10'(k)}, 1'h0, 1'h0, 1'h1);
                chk_bit(ioSelN, k > 3);
                chk_val(20'(portIdx), 20'(k % 4));
            end
            host({10'h000, b}, 1'h1, 1'h0, 1'h1);
            chk_bit(ioSelN, 1'h1);
        end
        $display("io window test done");
        foreach (roms[i]) begin
            strapN.romSel <= roms[i];
            r = {3'h6, roms[i], 13'h0000};
            host(r + 20'h01abc, 1'h1, 1'h1, 1'h0);
            chk_bit(romSelN, 1'h0);
            host(r + 20'h02000, 1'h0, 1'h1, 1'h0);
            chk_bit(romSelN, 1'h1);
        end
        $display("rom window test done");
        host(20'h00000, 1'h1, 1'h1, 1'h1);
        for (int c = 0; c < 3; c++) begin
            strapN.dmaSel <= hbd_pkg::hbd_dma_type'(c);
            slow <= c[0];
            ahb(1'h1, hbd_pkg::MADDR_OFS, 32'h000a5a50 + 32'(c));
            ahb(1'h1, hbd_pkg::CTRL_OFS, 32'h00000001);
            n = 0;
            while (drq === 3'h0 && n < 50) step(n);
            chk_val(20'(drq), 20'(3'h1 << c));
            while (memrN !== 1'h0 && n < 200) step(n);
            chk_val(saOut, 20'ha5a50 + 20'(c));
            chk_bit(memrOe && saOe && !masterN, 1'h1);
            while (masterN !== 1'h1 && n < 400) step(n);
            chk_bit(masterN, 1'h1);
            ahb(1'h0, hbd_pkg::RDATA_OFS, 32'h00000000);
            chk_val(q[19:0], {4'h0, 8'h50 + 8'(c), 8'h5a});
        end
        $display("dma ownership test done");
        ahb(1'h1, hbd_pkg::WDATA_OFS, 32'h0000c33c);
        ahb(1'h1, hbd_pkg::CTRL_OFS, 32'h00000003);
        n = 0;
        while (sdOe !== 1'h1 && n < 200) step(n);
        chk_val(20'(sdOut), 20'h0c33c);
        chk_bit(saOe && !masterN && memrN, 1'h1);
        while (masterN !== 1'h1 && n < 400) step(n);
        chk_bit(sdOe, 1'h0);
        $display("dma write test done");
        ahb(1'h0, hbd_pkg::STAT_OFS, 32'h00000000);
        chk_val(q[19:0], 20'h00000);
        chk_val(20'(irqOut), 20'h00000);
        ahb(1'h0, hbd_pkg::STRAP_OFS, 32'h00000000);
        chk_val(q[19:0], 20'({5'h0a, 4'h5, 2'h2, 4'h3}));
        ahb(1'h0, 8'h3c, 32'h00000000);
        chk_val(q[19:0], 20'h00000);
        chk_bit(hresp, 1'h0);
        $display("register bus test done");
        final_report();
    end
endmodule // hbd_host_bus_address_decode_tb_top

/* verification/hbd_host_model.sv */
`timescale 1ns/1ps

// ==========================================================
// Host DMA controller and memory
module hbd_host_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic [2:0] drq,
    input wire logic [19:0] saOut,
    input wire logic saOe,
    input wire logic memrN,
    input wire logic memrOe,
    output logic [2:0] dackN,
    output logic [15:0] sdIn
);
    logic [3:0] waitCnt_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            waitCnt_r <= 4'h0;
            dackN <= 3'h7;
        end else if (drq == 3'h0) begin
            waitCnt_r <= 4'h0;
            dackN <= 3'h7;
        end else if (waitCnt_r < (slow ? 4'hc : 4'h1)) begin
            waitCnt_r <= waitCnt_r + 4'h1;
        end else begin
            dackN <= ~drq;
        end
    end
    // Outside a read the lines toggle so stale data never looks valid
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sdIn <= 16'h0000;
        end else if (!memrN && memrOe && saOe) begin
            sdIn <= {saOut[7:0], saOut[15:8]};
        end else begin
            sdIn <= ~sdIn;
        end
    end
endmodule // hbd_host_model
